// [tvsel_pkg.sv]
// Constants shared by the tuning and selection control block
// Assumes a single 10 MHz system clock and synchronous active-high reset
//
// Behaviour
// - Channel-mode high: step key falling edge steps program 0..29 with wrap
// - Channel-mode low: channel shown; keys ring-count tens and units, no carry
// - Search advances channel every 250 ms, 99 wraps to 0
// - Search ends on stop falling edge, mode back to program, or digit key
// - Search stopped by stop signal never resumes when stop goes inactive
// - Search-active output high for the whole search
// - Held fine-tune key steps 4 per second, limited +3.875 to -4 MHz
// - At a tuning limit the channel indication blinks every 0.5 s
// - Store press saves tuning under displayed program, display unchanged
// - Mute high 100 ms before each tuning output until 20 ms after
// - Mute also high during search and while stop signal is absent
// - Remote direct-channel shows channel; 8 s idle returns to program
// - Every instruction restarts 8 s timeout; counting starts after release
// - First remote digit sets tens, units shows dash; second digit loads tuning
// - Remote fine tune: short press one step, held repeats every 250 ms
// - Remote overflow blinks only if channel indication was already visible
// - End-of-instruction flag set 8 s after last repeat, and by external cmd
// - Remote store saves channel and offset, returns to program; blocked in search
// - Remote tens-up adds 10 mod 100; units-up adds 1 mod 10, no carry
// - Remote search starts on new press only, stops on transmitter found
// - Other remote commands except store stop search; external cmd to program, digits and others stay channel
// - Two straps select feature set per the four combinations
// - Each fine-tune step moves offset by 125 kHz
package tvsel_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned SEARCH_MS     = 250;
	localparam int unsigned FT_MS         = 250;
	localparam int unsigned BLINK_MS      = 500;
	localparam int unsigned MUTE_PRE_MS   = 100;
	localparam int unsigned MUTE_POST_MS  = 20;
	localparam int unsigned IDLE_MS       = 8000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned SEARCH_CYC    = SEARCH_MS * CYC_PER_MS;
	localparam int unsigned FT_CYC        = FT_MS * CYC_PER_MS;
	localparam int unsigned BLINK_CYC     = BLINK_MS * CYC_PER_MS;
	localparam int unsigned MUTE_PRE_CYC  = MUTE_PRE_MS * CYC_PER_MS;
	localparam int unsigned MUTE_POST_CYC = MUTE_POST_MS * CYC_PER_MS;
	localparam int unsigned IDLE_CYC      = IDLE_MS * CYC_PER_MS;
	// Program range and tuning offset in 125 kHz steps
	localparam logic [4:0] PROG_MAX     = 5'h1d;
	localparam logic [6:0] FT_STEP_KHZ  = 7'h7d;
	localparam logic signed [5:0] FT_MAX = 6'sh1f;
	localparam logic signed [5:0] FT_MIN = -6'sh20;
	// Reset values
	localparam logic [4:0] PROG_RST   = 5'h01;
	localparam logic [3:0] TENS_RST   = 4'h0;
	localparam logic [3:0] UNITS_RST  = 4'h1;
	// Remote command codes
	typedef enum logic [3:0] {
		TVSEL_RC_NONE, TVSEL_RC_DIGIT, TVSEL_RC_CHAN, TVSEL_RC_STORE,
		TVSEL_RC_SEARCH, TVSEL_RC_FT_UP, TVSEL_RC_FT_DN, TVSEL_RC_P_UP,
		TVSEL_RC_P_DN, TVSEL_RC_EXT
	} tvsel_rc_t;
	typedef enum logic [1:0] {
		TVSEL_TO_IDLE, TVSEL_TO_PRE, TVSEL_TO_POST
	} tvsel_out_t;
endpackage

// [tvsel_sync.sv]
// Two-flop synchroniser with falling-edge detect for active-low keys
// Assumes inputs are asynchronous pins
`timescale 1ns/1ps
module tvsel_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Pins and results
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level,
	output logic      [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} tvsel_sy_t;
	tvsel_sy_t st_r, st_nxt;
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end
	always_ff @(posedge clk) begin
		if (rst)
			st_r <= '{default: '1};
		else
			st_r <= st_nxt;
	end
	assign level = st_r.s2;
	assign fall  = st_r.s3 & ~st_r.s2;
endmodule // tvsel_sync

// [tvsel_timer.sv]
// Reloadable down-counter giving a one-cycle pulse on expiry
// Assumes load and run come from logic on the same clock
`timescale 1ns/1ps
module tvsel_timer #(
	parameter int unsigned N = 16
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic load,
	input  wire logic run,
	input  wire logic [31:0] count,
	// Status
	output logic      busy,
	output logic      done
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        done;
	} tvsel_tm_t;
	tvsel_tm_t st_r, st_nxt;
	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		if (load)
			st_nxt.cnt = count;
		else if (run && st_r.cnt != 32'h0) begin
			st_nxt.cnt = st_r.cnt - 32'h1;
			st_nxt.done = (st_r.cnt == 32'h1);
		end
	end
	always_ff @(posedge clk) begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign busy = (st_r.cnt != 32'h0);
	assign done = st_r.done;
endmodule // tvsel_timer

// [tvsel_ctrl.sv]
// Tuning and selection control: program/channel selection, search,
// fine tuning, store, mute and remote 8 s channel mode.
// Assumes panel keys are active-low pins; remote commands arrive as a code
// held while the remote button is held (code NONE when released).
`timescale 1ns/1ps
module tvsel_ctrl #(
	parameter int unsigned SEARCH_CYC    = tvsel_pkg::SEARCH_CYC,
	parameter int unsigned FT_CYC        = tvsel_pkg::FT_CYC,
	parameter int unsigned BLINK_CYC     = tvsel_pkg::BLINK_CYC,
	parameter int unsigned MUTE_PRE_CYC  = tvsel_pkg::MUTE_PRE_CYC,
	parameter int unsigned MUTE_POST_CYC = tvsel_pkg::MUTE_POST_CYC,
	parameter int unsigned IDLE_CYC      = tvsel_pkg::IDLE_CYC
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Panel keys, active low pins
	input  wire logic       channel_mode_select_n,
	input  wire logic       prog_up_n,
	input  wire logic       prog_dn_n,
	input  wire logic       search_start_key_n,
	input  wire logic       tune_up_key_n,
	input  wire logic       tune_down_key_n,
	input  wire logic       store_key_n,
	input  wire logic       stop_n,
	// Straps
	input  wire logic       reduced_feature_strap,
	input  wire logic       no_storage_strap,
	// Remote receiver
	input  wire logic [3:0] rc_code,
	input  wire logic [3:0] rc_digit,
	// Tuning word out
	output logic [3:0]      tune_tens,
	output logic [3:0]      tune_units,
	output logic [5:0]      tune_offset,
	output logic            tune_load,
	// Store to memory
	output logic [4:0]      store_prog,
	output logic            store_req,
	// Display
	output logic [4:0]      prog_num,
	output logic            chan_show,
	output logic            chan_blank,
	output logic            units_dash,
	// Status
	output logic            mute,
	output logic            search_active_out,
	output logic            channel_mode_out,
	output logic            end_instr_flag
);
	// ====================================================================
	// Input synchronisation
	logic [7:0] pin_lvl, pin_fall;
	logic [3:0] rc_s1_r, rc_s2_r, rc_prev_r, dg_s1_r, dg_s2_r;
	tvsel_sync #(.W(8)) u_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   ({stop_n, store_key_n, tune_down_key_n, tune_up_key_n,
		         search_start_key_n, prog_dn_n, prog_up_n,
		         channel_mode_select_n}),
		.level (pin_lvl),
		.fall  (pin_fall)
	);
	always_ff @(posedge clk) begin
		if (rst) begin
			rc_s1_r   <= 4'h0;
			rc_s2_r   <= 4'h0;
			rc_prev_r <= 4'h0;
			dg_s1_r   <= 4'h0;
			dg_s2_r   <= 4'h0;
		end else begin
			rc_s1_r   <= rc_code;
			rc_s2_r   <= rc_s1_r;
			rc_prev_r <= rc_s2_r;
			dg_s1_r   <= rc_digit;
			dg_s2_r   <= dg_s1_r;
		end
	end
	logic channel_mode_select_chan, stop_act, stop_fall;
	logic rc_new, rc_held, rc_rel;
	assign channel_mode_select_chan = ~pin_lvl[0];
	assign stop_act   = ~pin_lvl[7];
	assign stop_fall  = pin_fall[7];
	assign rc_new  = (rc_s2_r != rc_prev_r) && (rc_s2_r != 4'h0);
	assign rc_held = (rc_s2_r != 4'h0);
	assign rc_rel  = (rc_s2_r == 4'h0) && (rc_prev_r != 4'h0);

	// ====================================================================
	// Feature set from straps
	logic ext_prog, allow_store, allow_chan, allow_ft;
	assign ext_prog    = ~no_storage_strap;
	assign allow_store = ~reduced_feature_strap & ~no_storage_strap;
	assign allow_chan  = ~reduced_feature_strap | no_storage_strap;
	assign allow_ft    = ~reduced_feature_strap;

	// ====================================================================
	// State
	typedef struct packed {
		logic [4:0]        prog;
		logic [3:0]        tens;
		logic [3:0]        units;
		logic signed [5:0] ft;
		logic              search;
		logic              rc_chan;
		logic              dash;
		logic              ft_lim;
		logic              blink_ok;
		logic              blink;
		logic              eoi;
		logic              ft_dir;
		logic              ft_run;
		logic              load_pend;
		logic              store;
		tvsel_pkg::tvsel_out_t out;
	} tvsel_st_t;
	tvsel_st_t st_r, st_nxt;

	logic tick_search, tick_ft, tick_blink, idle_done, mute_done;
	logic idle_busy, mute_busy, ld_idle, ld_mute, blink_busy;
	logic [31:0] mute_cnt;
	tvsel_timer u_search (.clk(clk), .rst(rst), .load(~st_r.search | tick_search),
		.run(st_r.search), .count(32'(SEARCH_CYC)), .busy(),
		.done(tick_search));
	tvsel_timer u_ft (.clk(clk), .rst(rst), .load(~st_r.ft_run | tick_ft),
		.run(st_r.ft_run), .count(32'(FT_CYC)), .busy(), .done(tick_ft));
	// Reloads itself when empty; a zero count would otherwise never restart
	tvsel_timer u_blink (.clk(clk), .rst(rst), .load(~blink_busy),
		.run(st_r.ft_lim), .count(32'(BLINK_CYC)), .busy(blink_busy),
		.done(tick_blink));
	// Idle count held while remote button is down
	tvsel_timer u_idle (.clk(clk), .rst(rst), .load(ld_idle),
		.run(~rc_held), .count(32'(IDLE_CYC)), .busy(idle_busy),
		.done(idle_done));
	tvsel_timer u_mute (.clk(clk), .rst(rst), .load(ld_mute),
		.run(st_r.out != tvsel_pkg::TVSEL_TO_IDLE), .count(mute_cnt),
		.busy(mute_busy), .done(mute_done));
	assign ld_idle = rc_new | (rc_held & (rc_s2_r != rc_prev_r));

	function automatic logic [3:0] inc10(input logic [3:0] v);
		inc10 = (v == 4'h9) ? 4'h0 : v + 4'h1;
	endfunction

	tvsel_pkg::tvsel_rc_t rc;
	logic chan_mode, ft_up_key, ft_dn_key;
	always_comb begin
		st_nxt    = st_r;
		rc        = tvsel_pkg::tvsel_rc_t'(rc_new ? rc_s2_r : 4'h0);
		chan_mode = (channel_mode_select_chan & ext_prog) | st_r.rc_chan | ~ext_prog;
		ft_up_key = ~pin_lvl[4] | (allow_ft & rc_s2_r == 4'h5);
		ft_dn_key = ~pin_lvl[5] | (allow_ft & rc_s2_r == 4'h6);
		st_nxt.store = 1'b0;
		if (st_r.load_pend && st_r.out == tvsel_pkg::TVSEL_TO_IDLE)
			st_nxt.load_pend = 1'b0;
		// Panel stepping
		if (!chan_mode && pin_fall[1])
			st_nxt.prog = (st_r.prog == tvsel_pkg::PROG_MAX) ? 5'h0
				: st_r.prog + 5'h1;
		if (!chan_mode && pin_fall[2])
			st_nxt.prog = (st_r.prog == 5'h0) ? tvsel_pkg::PROG_MAX
				: st_r.prog - 5'h1;
		if (chan_mode && pin_fall[1]) begin
			st_nxt.units = inc10(st_r.units);
			st_nxt.search = 1'b0;
			st_nxt.load_pend = 1'b1;
		end
		if (chan_mode && pin_fall[2]) begin
			st_nxt.tens = inc10(st_r.tens);
			st_nxt.search = 1'b0;
			st_nxt.load_pend = 1'b1;
		end
		if (chan_mode && pin_fall[3]) begin
			st_nxt.search = 1'b1;
			st_nxt.eoi = 1'b0;
		end
		if (pin_fall[6] && allow_store)
			st_nxt.store = 1'b1;
		// Remote commands
		if (rc != tvsel_pkg::TVSEL_RC_NONE)
			st_nxt.eoi = 1'b0;
		unique case (rc)
			tvsel_pkg::TVSEL_RC_NONE: ;
			tvsel_pkg::TVSEL_RC_DIGIT: begin
				st_nxt.search = 1'b0;
				if (allow_chan) begin
					st_nxt.rc_chan = ext_prog;
					if (!st_r.dash) begin
						st_nxt.tens = dg_s2_r;
						st_nxt.dash = 1'b1;
					end else begin
						st_nxt.units = dg_s2_r;
						st_nxt.dash = 1'b0;
						st_nxt.load_pend = 1'b1;
					end
				end
			end
			tvsel_pkg::TVSEL_RC_CHAN:
				if (allow_store) begin
					st_nxt.search = 1'b0;
					st_nxt.rc_chan = 1'b1;
				end
			tvsel_pkg::TVSEL_RC_STORE:
				if (allow_store && !st_r.search) begin
					st_nxt.store = 1'b1;
					st_nxt.rc_chan = 1'b0;
					st_nxt.dash = 1'b0;
				end
			tvsel_pkg::TVSEL_RC_SEARCH:
				if (!st_r.search) begin
					st_nxt.search = 1'b1;
					st_nxt.rc_chan = ext_prog;
				end
			tvsel_pkg::TVSEL_RC_FT_UP, tvsel_pkg::TVSEL_RC_FT_DN: begin
				st_nxt.search = 1'b0;
				st_nxt.blink_ok = chan_mode;
			end
			tvsel_pkg::TVSEL_RC_P_UP:
				if (!reduced_feature_strap) begin
					st_nxt.search = 1'b0;
					if (chan_mode) begin
						st_nxt.units = inc10(st_r.units);
						st_nxt.load_pend = 1'b1;
					end else
						st_nxt.prog = (st_r.prog == tvsel_pkg::PROG_MAX)
							? 5'h0 : st_r.prog + 5'h1;
				end
			tvsel_pkg::TVSEL_RC_P_DN:
				if (!reduced_feature_strap) begin
					st_nxt.search = 1'b0;
					if (chan_mode) begin
						st_nxt.tens = inc10(st_r.tens);
						st_nxt.load_pend = 1'b1;
					end else
						st_nxt.prog = (st_r.prog == 5'h0)
							? tvsel_pkg::PROG_MAX : st_r.prog - 5'h1;
				end
			tvsel_pkg::TVSEL_RC_EXT: begin
				st_nxt.search = 1'b0;
				st_nxt.rc_chan = 1'b0;
				st_nxt.dash = 1'b0;
				st_nxt.eoi = 1'b1;
			end
			default: ;
		endcase
		// Search stepping and termination
		if (st_r.search && tick_search) begin
			st_nxt.load_pend = 1'b1;
			if (st_r.units == 4'h9) begin
				st_nxt.units = 4'h0;
				st_nxt.tens = inc10(st_r.tens);
			end else
				st_nxt.units = st_r.units + 4'h1;
		end
		// The stop edge or program mode ends a search; stop release never restarts it
		if (stop_fall || (!chan_mode && !st_nxt.rc_chan))
			st_nxt.search = 1'b0;
		// Fine tuning with limits and repeat rate
		st_nxt.ft_run = ft_up_key ^ ft_dn_key;
		st_nxt.ft_dir = ft_up_key;
		if ((st_r.ft_run && tick_ft) ||
		    (rc == tvsel_pkg::TVSEL_RC_FT_UP && allow_ft) ||
		    (rc == tvsel_pkg::TVSEL_RC_FT_DN && allow_ft) ||
		    (pin_fall[4] | pin_fall[5])) begin
			if (ft_up_key && st_r.ft != tvsel_pkg::FT_MAX) begin
				st_nxt.ft = st_r.ft + 6'sh1;
				st_nxt.load_pend = 1'b1;
			end else if (ft_dn_key && st_r.ft != tvsel_pkg::FT_MIN) begin
				st_nxt.ft = st_r.ft - 6'sh1;
				st_nxt.load_pend = 1'b1;
			end
		end
		st_nxt.ft_lim = (st_nxt.ft == tvsel_pkg::FT_MAX) ||
			(st_nxt.ft == tvsel_pkg::FT_MIN);
		if (pin_fall[4] | pin_fall[5])
			st_nxt.blink_ok = 1'b1;
		if (tick_blink)
			st_nxt.blink = ~st_r.blink & st_r.ft_lim & st_r.blink_ok;
		if (!st_r.ft_lim)
			st_nxt.blink = 1'b0;
		// Remote 8 s channel mode and end-of-instruction
		if (idle_done) begin
			st_nxt.rc_chan = 1'b0;
			st_nxt.dash = 1'b0;
			st_nxt.eoi = 1'b1;
		end
		if (st_r.store)
			st_nxt.rc_chan = st_nxt.rc_chan;
		// Mute sequence around each tuning load
		unique case (st_r.out)
			tvsel_pkg::TVSEL_TO_IDLE:
				if (st_r.load_pend)
					st_nxt.out = tvsel_pkg::TVSEL_TO_PRE;
			tvsel_pkg::TVSEL_TO_PRE:
				if (mute_done)
					st_nxt.out = tvsel_pkg::TVSEL_TO_POST;
			tvsel_pkg::TVSEL_TO_POST:
				if (mute_done)
					st_nxt.out = tvsel_pkg::TVSEL_TO_IDLE;
		endcase
		// Events during a sequence stay pending for the next one
	end
	assign ld_mute = (st_r.out == tvsel_pkg::TVSEL_TO_IDLE && st_r.load_pend)
		|| (st_r.out == tvsel_pkg::TVSEL_TO_PRE && mute_done);
	assign mute_cnt = (st_r.out == tvsel_pkg::TVSEL_TO_IDLE)
		? 32'(MUTE_PRE_CYC) : 32'(MUTE_POST_CYC);

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r       <= '0;
			st_r.prog  <= tvsel_pkg::PROG_RST;
			st_r.tens  <= tvsel_pkg::TENS_RST;
			st_r.units <= tvsel_pkg::UNITS_RST;
			st_r.eoi   <= 1'b1;
			st_r.out   <= tvsel_pkg::TVSEL_TO_IDLE;
		end else
			st_r <= st_nxt;
	end

	// ====================================================================
	// Outputs; tuning word is latched at end of the pre-mute wait
	logic [3:0] tt_r, tu_r;
	logic [5:0] to_r;
	logic       tl_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			tt_r <= 4'h0;
			tu_r <= 4'h0;
			to_r <= 6'h0;
			tl_r <= 1'b0;
		end else begin
			tl_r <= (st_r.out == tvsel_pkg::TVSEL_TO_PRE) && mute_done;
			if ((st_r.out == tvsel_pkg::TVSEL_TO_PRE) && mute_done) begin
				tt_r <= st_r.tens;
				tu_r <= st_r.units;
				to_r <= st_r.ft;
			end
		end
	end
	assign tune_tens   = tt_r;
	assign tune_units  = tu_r;
	assign tune_offset = to_r;
	assign tune_load   = tl_r;
	assign store_prog  = st_r.prog;
	assign store_req   = st_r.store;
	assign prog_num    = st_r.prog;
	assign channel_mode_out = (channel_mode_select_chan & ext_prog) | st_r.rc_chan
		| ~ext_prog;
	assign chan_show   = channel_mode_out | st_r.search;
	assign chan_blank  = st_r.blink;
	assign units_dash  = st_r.dash;
	assign search_active_out = st_r.search;
	assign mute = (st_r.out != tvsel_pkg::TVSEL_TO_IDLE) | st_r.search
		| ~stop_act;
	assign end_instr_flag = st_r.eoi;
endmodule // tvsel_ctrl

// [tvsel_panel.sv]
// Panel keys and remote receiver model
// Assumes the bench calls its tasks; it drives just after rising edges
`timescale 1ns/1ps
module tvsel_panel (
	// Clock
	input  wire logic clk,
	// Pins
	output logic [5:0] keys_n,
	output logic [3:0] rc_code,
	output logic [3:0] rc_digit
);
	initial begin
		keys_n = 6'h3f;
		rc_code = 4'h0;
		rc_digit = 4'hf;
	end
	// Key held n cycles, then released
	task automatic press(input int k, input int n);
		@(posedge clk);
		#1 keys_n[k] = 1'b0;
		repeat (n) @(posedge clk);
		#1 keys_n[k] = 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask
	// Digit lines float when idle, so they show the inverse
	task automatic send(input logic [3:0] c, input logic [3:0] d);
		@(posedge clk);
		#1 rc_code = c;
		rc_digit = d;
		repeat (4) @(posedge clk);
		#1 rc_code = 4'h0;
		rc_digit = ~d;
		repeat (4) @(posedge clk);
		#1;
	endtask
endmodule // tvsel_panel

// [tvsel_monitor.sv]
// Port properties of the tuning and selection control
// Assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
module tvsel_monitor #(
	parameter int unsigned MUTE_PRE_CYC  = 10,
	parameter int unsigned MUTE_POST_CYC = 5
) (
	// Clock, reset, inputs
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       stop_n,
	input wire logic [3:0] rc_code,
	// Outputs
	input wire logic [3:0] tune_tens,
	input wire logic [3:0] tune_units,
	input wire logic       tune_load,
	input wire logic       store_req,
	input wire logic [4:0] prog_num,
	input wire logic       chan_show,
	input wire logic       mute,
	input wire logic       search_active_out,
	input wire logic       end_instr_flag
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	int unsigned mute_run;
	int unsigned post_left;
	// ====================
	// Mute span counters
	always_ff @(posedge clk) begin
		if (rst || !mute)
			mute_run <= 0;
		else if (mute_run < MUTE_PRE_CYC)
			mute_run <= mute_run + 1;
		if (rst)
			post_left <= 0;
		else if (tune_load)
			post_left <= MUTE_POST_CYC;
		else if (post_left != 0)
			post_left <= post_left - 1;
	end
	sequence s_stop_hit;
		$fell(stop_n) && search_active_out;
	endsequence
	sequence s_stop_gone;
		$rose(stop_n) && !search_active_out && rc_code == 4'h0;
	endsequence
	a_load_lead: assert property (tune_load |-> mute_run >= MUTE_PRE_CYC)
		else $error("mute lead short");
	a_load_tail: assert property (post_left > 1 |-> mute)
		else $error("mute tail short");
	a_search_mute: assert property (search_active_out |-> mute)
		else $error("search unmuted");
	a_nostop_mute: assert property (stop_n [*4] |-> mute)
		else $error("no stop unmuted");
	a_stop_ends: assert property (s_stop_hit |-> ##[1:5] !search_active_out)
		else $error("stop ignored");
	a_no_resume: assert property (s_stop_gone |=> !search_active_out [*8])
		else $error("search resumed");
	a_prog_range: assert property (prog_num <= 5'h1d)
		else $error("program out of range");
	a_digit_range: assert property (tune_tens <= 4'h9 && tune_units <= 4'h9)
		else $error("digit out of range");
	a_search_show: assert property (search_active_out |-> chan_show)
		else $error("channel hidden in search");
	a_store_pulse: assert property (store_req |=> !store_req)
		else $error("store held");
	a_ext_flag: assert property (rc_code == 4'h9 |-> ##[1:5] end_instr_flag)
		else $error("flag not set");
endmodule // tvsel_monitor
bind tvsel_ctrl tvsel_monitor #(
	.MUTE_PRE_CYC(MUTE_PRE_CYC), .MUTE_POST_CYC(MUTE_POST_CYC)
) u_mon (
	.clk(clk), .rst(rst), .stop_n(stop_n), .rc_code(rc_code),
	.tune_tens(tune_tens), .tune_units(tune_units),
	.tune_load(tune_load), .store_req(store_req), .prog_num(prog_num),
	.chan_show(chan_show), .mute(mute),
	.search_active_out(search_active_out), .end_instr_flag(end_instr_flag)
);

// [tv_tuning_selection_control_tb.sv]
// Self-checking bench for the tuning and selection control
// Assumes tvsel_panel drives keys and remote; timers are shortened
`timescale 1ns/1ps
module tv_tuning_selection_control_tb;
	logic       clk, rst, mode_n, stop_n, red, nost;
	logic [5:0] keys_n, offs;
	logic [3:0] rc_code, rc_digit, tens, units;
	logic [4:0] st_prog, prog, last_prog;
	logic       load, st_req, show, blank, dash, mute, srch, cmode, eoi;
	logic [1:0] seen;
	int         n_fail = 0;
	int         check_count = 0;
	int         n_store = 0;
	int         n0, i;
	tvsel_panel u_pan (.clk(clk), .keys_n(keys_n), .rc_code(rc_code),
		.rc_digit(rc_digit));
	tvsel_ctrl #(
		.SEARCH_CYC(20), .FT_CYC(20), .BLINK_CYC(30),
		.MUTE_PRE_CYC(10), .MUTE_POST_CYC(5), .IDLE_CYC(100)
	) dut (
		.clk(clk), .rst(rst), .channel_mode_select_n(mode_n),
		.prog_up_n(keys_n[0]), .prog_dn_n(keys_n[1]),
		.search_start_key_n(keys_n[2]), .tune_up_key_n(keys_n[3]),
		.tune_down_key_n(keys_n[4]), .store_key_n(keys_n[5]),
		.stop_n(stop_n), .reduced_feature_strap(red),
		.no_storage_strap(nost), .rc_code(rc_code), .rc_digit(rc_digit),
		.tune_tens(tens), .tune_units(units), .tune_offset(offs),
		.tune_load(load), .store_prog(st_prog), .store_req(st_req),
		.prog_num(prog), .chan_show(show), .chan_blank(blank),
		.units_dash(dash), .mute(mute), .search_active_out(srch),
		.channel_mode_out(cmode), .end_instr_flag(eoi)
	);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Store pulses are one cycle, so they are counted as they pass
	always @(posedge clk) begin
		if (st_req === 1'b1) begin
			n_store <= n_store + 1;
			last_prog <= st_prog;
		end
	end
	// ====================
	// Common tasks
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic key(input int k);
		u_pan.press(k, 4);
		cyc(30);
	endtask
	task automatic wait_load();
		int k;
		for (k = 0; k < 600 && load !== 1'b1; k++)
			cyc(1);
		check(8'(k < 600), 8'h01);
		cyc(1);
	endtask
	task automatic do_reset();
		rst = 1'b1;
		cyc(12);
		rst = 1'b0;
		cyc(4);
	endtask
	// ====================
	// Scenarios
	task automatic t_prog();
		check(prog, 5'h01);
		check({tens, units}, 8'h00);
		check(offs, 6'h00);
		check(eoi, 1'b1);
		for (i = 0; i < 28; i++)
			key(0);
		check(prog, 5'h1d);
		key(0);
		check(prog, 5'h00);
		key(1);
		check(prog, 5'h1d);
	endtask
	task automatic t_chan();
		mode_n = 1'b0;
		cyc(30);
		check(show, 1'b1);
		for (i = 0; i < 9; i++)
			key(0);
		check({tens, units}, 8'h00);
		for (i = 0; i < 9; i++)
			key(1);
		for (i = 0; i < 8; i++)
			key(0);
		check({tens, units}, 8'h98);
	endtask
	task automatic t_search();
		stop_n = 1'b1;
		cyc(10);
		u_pan.press(2, 4);
		check(srch, 1'b1);
		for (i = 0; i < 4 && {tens, units} !== 8'h99; i++)
			wait_load();
		check({tens, units}, 8'h99);
		wait_load();
		check({tens, units}, 8'h00);
		stop_n = 1'b0;
		cyc(8);
		check(srch, 1'b0);
		stop_n = 1'b1;
		cyc(60);
		check(srch, 1'b0);
		check(mute, 1'b1);
		stop_n = 1'b0;
		cyc(30);
	endtask
	task automatic t_fine();
		fork
			u_pan.press(3, 1200);
		join_none
		wait_load();
		check(offs, 6'h01);
		for (i = 0; i < 40 && offs !== 6'h1f; i++)
			wait_load();
		seen = 2'b00;
		repeat (100) begin
			cyc(1);
			if (blank === 1'b1)
				seen[1] = 1'b1;
			else
				seen[0] = 1'b1;
		end
		check(seen, 2'b11);
		check(offs, 6'h1f);
		wait fork;
		cyc(30);
		u_pan.press(4, 4);
		wait_load();
		check(offs, 6'h1e);
		cyc(30);
	endtask
	task automatic t_store();
		n0 = n_store;
		key(5);
		check(8'(n_store - n0), 8'h01);
		check(last_prog, 5'h1d);
		check(prog, 5'h1d);
	endtask
	task automatic t_remote();
		mode_n = 1'b1;
		cyc(30);
		u_pan.send(4'h2, 4'h0);
		check(cmode, 1'b1);
		check(show, 1'b1);
		u_pan.send(4'h1, 4'h3);
		check(dash, 1'b1);
		u_pan.send(4'h1, 4'h4);
		cyc(30);
		check({tens, units}, 8'h34);
		check(dash, 1'b0);
		u_pan.send(4'h8, 4'h0);
		cyc(30);
		check({tens, units}, 8'h44);
		u_pan.send(4'h7, 4'h0);
		cyc(30);
		check({tens, units}, 8'h45);
		cyc(30);
		check(cmode, 1'b1);
		cyc(50);
		check(cmode, 1'b0);
		u_pan.send(4'h2, 4'h0);
		n0 = n_store;
		u_pan.send(4'h3, 4'h0);
		check(8'(n_store - n0), 8'h01);
		check(cmode, 1'b0);
	endtask
	task automatic t_rsearch();
		stop_n = 1'b1;
		cyc(10);
		u_pan.send(4'h4, 4'h0);
		check(srch, 1'b1);
		check(cmode, 1'b1);
		n0 = n_store;
		u_pan.send(4'h3, 4'h0);
		check(8'(n_store - n0), 8'h00);
		check(srch, 1'b1);
		u_pan.send(4'h9, 4'h0);
		check(srch, 1'b0);
		check(cmode, 1'b0);
		check(eoi, 1'b1);
		stop_n = 1'b0;
	endtask
	task automatic t_rfine();
		cyc(40);
		u_pan.send(4'h5, 4'h0);
		wait_load();
		check(offs, 6'h1f);
		seen = 2'b00;
		repeat (70) begin
			cyc(1);
			if (blank !== 1'b0)
				seen[1] = 1'b1;
		end
		check(seen, 2'b00);
		u_pan.send(4'h6, 4'h0);
		wait_load();
		check(offs, 6'h1e);
	endtask
	task automatic t_strap();
		red = 1'b1;
		do_reset();
		u_pan.send(4'h2, 4'h0);
		check(cmode, 1'b0);
		red = 1'b0;
		nost = 1'b1;
		do_reset();
		check(cmode, 1'b1);
	endtask
	initial begin
		mode_n = 1'b1;
		stop_n = 1'b0;
		red = 1'b0;
		nost = 1'b0;
		do_reset();
		t_prog();
		t_chan();
		t_search();
		t_fine();
		t_store();
		t_remote();
		t_rsearch();
		t_rfine();
		t_strap();
		give_verdict();
	end
	// Watchdog well past the expected few thousand cycles
	initial begin
		#4000000;
		n_fail++;
		give_verdict();
	end
endmodule // tv_tuning_selection_control_tb
